// ---- erc_pkg.sv ----
package erc_pkg;

   // device operating modes as seen by this block
   typedef enum logic [5:0] {
      MODE_INIT      = 6'h01,
      MODE_NORMAL    = 6'h02,
      MODE_STOP      = 6'h04,
      MODE_SLEEP     = 6'h08,
      MODE_RESTART   = 6'h10,
      MODE_FAIL_SAFE = 6'h20
   } erc_mode_e;

   // configuration lock state, one-hot
   typedef enum logic [2:0] {
      CFG_NONE       = 3'h1,
      CFG_STANDALONE = 3'h2,
      CFG_LOAD_SHARE = 3'h4
   } erc_cfg_e;

   // reset values of the held control state
   localparam logic RST_REG_ENABLE = 1'b0;
   localparam logic RST_HIGH_POWER = 1'b0;
   localparam logic RST_OC_FLAG = 1'b0;
   localparam logic RST_UV_FLAG = 1'b0;
   localparam logic RST_FAIL_FLAG = 1'b0;

   // output voltage code: 0 selects 3.3 V, 1 selects 1.8 V
   localparam logic VSEL_3V3 = 1'b0;
   localparam logic VSEL_1V8 = 1'b1;

endpackage : erc_pkg

// ---- erc_ctrl.sv ----
// Functional notes
// - on-bit in normal, share zero: lock standalone
// - first share-bit set locks load share
// - chosen configuration fixed until power removed
// - standalone voltage bit picks 3.3/1.8; share ignores
// - standalone off in init/failsafe, held elsewhere
// - load share follows main regulator per mode
// - stop disables sharing unless stay-in-stop set
// - change after share lock sets spi fail
// - standalone keeps on/off control, no fail
// - standalone overcurrent: limit, set clearable flag
// - load share never sets overcurrent flag
// - standalone reports undervoltage in status bit
// - load share: no undervoltage, off in failsafe
// - battery undervoltage switches off unless keep-on
// - stop uses low power, high power on threshold
// - normal mode runs high power regulator only
module erc_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic por_rst,
   input wire erc_pkg::erc_mode_e mode,
   input wire logic aux_reg_on,
   input wire logic load_share_select,
   input wire logic aux_voltage_select,
   input wire logic load_share_stay_in_stop,
   input wire logic keep_on_at_supply_uv,
   input wire logic ctrl_write,
   input wire logic oc_flag_clear,
   input wire logic uv_flag_clear,
   input wire logic fail_flag_clear,
   input wire logic main_reg_on,
   input wire logic shunt_limit_pin,
   input wire logic output_uv_pin,
   input wire logic battery_uv_pin,
   input wire logic base_above_rise_pin,
   input wire logic base_below_fall_pin,
   output logic aux_enable_q,
   output logic high_power_en_q,
   output logic low_power_en_q,
   output logic current_limit_q,
   output logic aux_voltage_q,
   output logic cfg_standalone_q,
   output logic cfg_load_share_q,
   output logic aux_overcurrent_flag_q,
   output logic aux_undervoltage_flag_q,
   output logic spi_fail_q
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: analog comparators arrive asynchronously
   ////////////////////////////////////////////////////////////////////////////

   localparam int NSYNC = 5;
   logic [NSYNC-1:0] pin_raw; // raw comparator levels
   logic [NSYNC-1:0] pin_m_q; // first stage, read by second only
   logic [NSYNC-1:0] pin_s_q; // synchronised levels

   assign pin_raw = {base_below_fall_pin, base_above_rise_pin, battery_uv_pin,
                     output_uv_pin, shunt_limit_pin};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         // two flops per pin
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               pin_m_q[gi] <= 1'b0;
               pin_s_q[gi] <= 1'b0;
            end else begin
               pin_m_q[gi] <= pin_raw[gi];
               pin_s_q[gi] <= pin_m_q[gi];
            end
         end
      end
   endgenerate

   logic shunt_hit; // shunt threshold reached
   logic out_uv; // aux output below its threshold
   logic batt_uv; // battery below its threshold
   logic base_rise; // base current above rising threshold
   logic base_fall; // base current below falling threshold

   assign shunt_hit = pin_s_q[0];
   assign out_uv = pin_s_q[1];
   assign batt_uv = pin_s_q[2];
   assign base_rise = pin_s_q[3];
   assign base_fall = pin_s_q[4];

   ////////////////////////////////////////////////////////////////////////////
   // configuration lock
   ////////////////////////////////////////////////////////////////////////////

   erc_pkg::erc_cfg_e cfg_q; // lock state
   logic share_stored_q; // set once load share locks, cleared only by power-on reset

   // only power-on reset clears the lock; soft reset and mode changes leave it
   always_ff @(posedge clk) begin
      if (por_rst) begin
         cfg_q <= erc_pkg::CFG_NONE;
      end else begin
         case (cfg_q)
            erc_pkg::CFG_NONE: begin
               if (ctrl_write && load_share_select) begin
                  cfg_q <= erc_pkg::CFG_LOAD_SHARE;
               end else if (ctrl_write && aux_reg_on &&
                            mode == erc_pkg::MODE_NORMAL) begin
                  cfg_q <= erc_pkg::CFG_STANDALONE;
               end
            end
            // locked states never leave until power goes away
            erc_pkg::CFG_STANDALONE: cfg_q <= erc_pkg::CFG_STANDALONE;
            erc_pkg::CFG_LOAD_SHARE: cfg_q <= erc_pkg::CFG_LOAD_SHARE;
            default: cfg_q <= erc_pkg::CFG_NONE;
         endcase
      end
   end

   // share bit is latched once and never cleared while powered
   always_ff @(posedge clk) begin
      if (por_rst) begin
         share_stored_q <= 1'b0;
      end else if (cfg_q == erc_pkg::CFG_LOAD_SHARE) begin
         share_stored_q <= 1'b1;
      end
   end

   logic is_sa; // standalone locked
   logic is_ls; // load share locked
   assign is_sa = (cfg_q == erc_pkg::CFG_STANDALONE);
   assign is_ls = (cfg_q == erc_pkg::CFG_LOAD_SHARE);

   // decoded configuration, registered for clean outputs
   always_ff @(posedge clk) begin
      if (por_rst) begin
         cfg_standalone_q <= 1'b0;
         cfg_load_share_q <= 1'b0;
      end else begin
         cfg_standalone_q <= is_sa;
         cfg_load_share_q <= is_ls;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // failure flag on illegal configuration change
   ////////////////////////////////////////////////////////////////////////////

   logic bad_change; // write tries to leave load share
   // in load share the on-bit has no function, so writing it or dropping share
   // is a change attempt; standalone attempts are silently ignored
   assign bad_change = ctrl_write && is_ls && (aux_reg_on || !load_share_select);

   // set wins over clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         spi_fail_q <= erc_pkg::RST_FAIL_FLAG;
      end else if (bad_change) begin
         spi_fail_q <= 1'b1;
      end else if (fail_flag_clear) begin
         spi_fail_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // standalone on/off request and voltage
   ////////////////////////////////////////////////////////////////////////////

   logic sa_on_q; // software on request, standalone
   logic sa_vsel_q; // latched voltage select

   // software control only in normal mode; held in stop, sleep, restart
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sa_on_q <= erc_pkg::RST_REG_ENABLE;
         sa_vsel_q <= erc_pkg::VSEL_3V3;
      end else if (mode == erc_pkg::MODE_INIT || mode == erc_pkg::MODE_FAIL_SAFE) begin
         sa_on_q <= 1'b0;
      end else if (ctrl_write && mode == erc_pkg::MODE_NORMAL && !is_ls &&
                   !(cfg_q == erc_pkg::CFG_NONE && load_share_select)) begin
         sa_on_q <= aux_reg_on;
         sa_vsel_q <= aux_voltage_select;
      end
   end
   // soft reset drops the on request, so software must switch on again after it

   // voltage bit applies only to standalone; share runs at main level
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aux_voltage_q <= erc_pkg::VSEL_3V3;
      end else begin
         aux_voltage_q <= is_sa ? sa_vsel_q : erc_pkg::VSEL_3V3;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable by mode and configuration
   ////////////////////////////////////////////////////////////////////////////

   logic mode_en; // enable before supply undervoltage gating
   // restart ignores main_reg_on: the main regulator is itself on or ramping then
   always_comb begin
      mode_en = 1'b0;
      if (is_sa) begin
         mode_en = sa_on_q;
      end else if (is_ls) begin
         case (mode)
            erc_pkg::MODE_NORMAL: mode_en = share_stored_q && main_reg_on;
            erc_pkg::MODE_RESTART: mode_en = 1'b1;
            erc_pkg::MODE_STOP: mode_en = load_share_stay_in_stop;
            erc_pkg::MODE_FAIL_SAFE: mode_en = 1'b0;
            default: mode_en = 1'b0;
         endcase
      end
   end

   // battery undervoltage forces off and releases automatically on recovery
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aux_enable_q <= erc_pkg::RST_REG_ENABLE;
      end else begin
         aux_enable_q <= mode_en && (!batt_uv || keep_on_at_supply_uv);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // low / high power regulator selection
   ////////////////////////////////////////////////////////////////////////////

   logic hp_stop_q; // high power engaged during stop

   // hysteresis between rising and falling base-current thresholds
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hp_stop_q <= erc_pkg::RST_HIGH_POWER;
      end else if (mode != erc_pkg::MODE_STOP) begin
         hp_stop_q <= 1'b0;
      end else if (base_rise) begin
         hp_stop_q <= 1'b1;
      end else if (base_fall) begin
         hp_stop_q <= 1'b0;
      end
   end

   // normal mode: high power only; stop: low power plus optional high power
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         high_power_en_q <= erc_pkg::RST_HIGH_POWER;
         low_power_en_q <= 1'b0;
      end else if (!mode_en || (batt_uv && !keep_on_at_supply_uv)) begin
         high_power_en_q <= 1'b0;
         low_power_en_q <= 1'b0;
      end else if (mode == erc_pkg::MODE_STOP) begin
         high_power_en_q <= hp_stop_q;
         low_power_en_q <= 1'b1;
      end else begin
         high_power_en_q <= 1'b1;
         low_power_en_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // protection flags
   ////////////////////////////////////////////////////////////////////////////

   // current limit acts only in standalone; in load share the shunt sets ratio
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         current_limit_q <= 1'b0;
      end else begin
         current_limit_q <= is_sa && aux_enable_q && shunt_hit;
      end
   end

   // clear is refused while the overcurrent condition persists (set wins)
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aux_overcurrent_flag_q <= erc_pkg::RST_OC_FLAG;
      end else if (is_sa && aux_enable_q && shunt_hit) begin
         aux_overcurrent_flag_q <= 1'b1;
      end else if (oc_flag_clear || is_ls) begin
         aux_overcurrent_flag_q <= 1'b0;
      end
   end

   // undervoltage monitoring enabled in standalone only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aux_undervoltage_flag_q <= erc_pkg::RST_UV_FLAG;
      end else if (is_sa && aux_enable_q && out_uv) begin
         aux_undervoltage_flag_q <= 1'b1;
      end else if (uv_flag_clear || is_ls) begin
         aux_undervoltage_flag_q <= 1'b0;
      end
   end

endmodule : erc_ctrl

// ---- erc_ctrl_assertions.sv ----
// watches the lock, the flags and the mode driven enables of the regulator control
module erc_ctrl_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic por_rst,
   input wire erc_pkg::erc_mode_e mode,
   input wire logic aux_reg_on,
   input wire logic load_share_select,
   input wire logic load_share_stay_in_stop,
   input wire logic ctrl_write,
   input wire logic aux_enable_q,
   input wire logic low_power_en_q,
   input wire logic cfg_standalone_q,
   input wire logic cfg_load_share_q,
   input wire logic aux_overcurrent_flag_q,
   input wire logic aux_undervoltage_flag_q,
   input wire logic spi_fail_q
);
   // soft reset is left out on purpose: the lock must survive it
   default clocking cb @(posedge clk); endclocking
   default disable iff (por_rst);
   ////////////////////////////////////////////////////////////////////////////////
   a_cfg_one_hot: assert property (!(cfg_standalone_q && cfg_load_share_q))
      else $error("both configurations shown at once");
   a_alone_kept: assert property (cfg_standalone_q && !$past(por_rst)
      |=> cfg_standalone_q)
      else $error("standalone lock dropped without power-on reset");
   a_share_kept: assert property (cfg_load_share_q && !$past(por_rst)
      |=> cfg_load_share_q)
      else $error("load share lock dropped without power-on reset");
   a_share_no_oc: assert property (cfg_load_share_q |-> !aux_overcurrent_flag_q)
      else $error("overcurrent flag set in load share");
   a_share_no_uv: assert property (cfg_load_share_q |-> !aux_undervoltage_flag_q)
      else $error("undervoltage flag set in load share");
   a_fail_on_change: assert property (disable iff (por_rst || sys_rst)
      cfg_load_share_q && ctrl_write && (aux_reg_on || !load_share_select) |=> spi_fail_q)
      else $error("refused change left spi fail clear");
   a_alone_no_fail: assert property (cfg_standalone_q |-> !$rose(spi_fail_q))
      else $error("spi fail raised in standalone");
   // three cycles of the same mode cover the register stage behind the mode input
   a_mode_off: assert property ((mode inside {erc_pkg::MODE_INIT,
      erc_pkg::MODE_FAIL_SAFE})[*3] |-> !aux_enable_q) else $error("enabled in init or fail safe");
   a_normal_no_lp: assert property ((mode == erc_pkg::MODE_NORMAL)[*3]
      |-> !low_power_en_q)
      else $error("low power stage on in normal mode");
   a_stop_share_off: assert property ((cfg_load_share_q && !load_share_stay_in_stop
      && mode == erc_pkg::MODE_STOP)[*3] |-> !aux_enable_q) else $error("sharing kept in stop");
endmodule : erc_ctrl_chk

bind erc_ctrl erc_ctrl_chk i_erc_ctrl_chk (.clk, .sys_rst, .por_rst, .mode, .aux_reg_on,
   .load_share_select, .load_share_stay_in_stop, .ctrl_write, .aux_enable_q, .low_power_en_q,
   .cfg_standalone_q, .cfg_load_share_q, .aux_overcurrent_flag_q, .aux_undervoltage_flag_q,
   .spi_fail_q);

// ---- erc_pnp_model.sv ----
// pass transistor and load: load 0 idle, 1 light, 2 heavy, 3 overload
module erc_pnp_model (
   input wire logic en,
   input wire logic [1:0] load,
   input wire logic sag,
   output logic shunt,
   output logic out_uv,
   output logic above,
   output logic below
);
   timeunit 1ns;
   timeprecision 1ps;
   // a switched off transistor carries no current, so off as well as idle shows below the fall point
   assign shunt = en && load == 2'h3;
   assign out_uv = en && sag;
   assign above = en && load >= 2'h2;
   assign below = !en || load == 2'h0;
endmodule : erc_pnp_model

// ---- test_ext_regulator_config_control.sv ----
module test_ext_regulator_config_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, sys_rst = 1, por_rst = 1, on = 0, ls = 0, vs = 0, stay = 0, keep = 0, wr = 0;
   logic occ = 0, main_on = 1, bat_uv = 0, sag = 0, v;
   logic [1:0] load = 2'h0;
   logic en, hp, lp, cl, vq, sa, sh, ocf, uvf, sf, shunt, ouv, above, below;
   erc_pkg::erc_mode_e mode = erc_pkg::MODE_INIT;
   erc_pkg::erc_mode_e ml[5] = '{erc_pkg::MODE_STOP, erc_pkg::MODE_SLEEP,
      erc_pkg::MODE_FAIL_SAFE, erc_pkg::MODE_RESTART, erc_pkg::MODE_INIT};
   int bad_count = 0, num_checks = 0;
   erc_ctrl i_erc_ctrl (.clk, .sys_rst, .por_rst, .mode, .aux_reg_on(on),
      .load_share_select(ls), .aux_voltage_select(vs), .load_share_stay_in_stop(stay),
      .keep_on_at_supply_uv(keep), .ctrl_write(wr), .oc_flag_clear(occ), .uv_flag_clear(occ),
      .fail_flag_clear(occ), .main_reg_on(main_on), .shunt_limit_pin(shunt),
      .output_uv_pin(ouv), .battery_uv_pin(bat_uv), .base_above_rise_pin(above),
      .base_below_fall_pin(below), .aux_enable_q(en), .high_power_en_q(hp), .low_power_en_q(lp),
      .current_limit_q(cl), .aux_voltage_q(vq), .cfg_standalone_q(sa), .cfg_load_share_q(sh),
      .aux_overcurrent_flag_q(ocf), .aux_undervoltage_flag_q(uvf), .spi_fail_q(sf));
   erc_pnp_model i_erc_pnp_model (.en, .load, .sag, .shunt, .out_uv(ouv), .above, .below);
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #5 clk = ~clk;
   // inputs always move 1 ns after the edge
   task tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task ck(logic s, logic e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : ck
   // control write pulse, then time for sync and register stages to settle
   task wr_ctl(logic o, logic l);
      on = o;
      ls = l;
      wr = 1;
      tick(1);
      wr = 0;
      tick(4);
   endtask : wr_ctl
   // one pulse clears every flag; a cause still present keeps its flag set
   task clr_oc();
      occ = 1;
      tick(1);
      occ = 0;
      tick(4);
   endtask : clr_oc
   // power-up: both resets together for 12 cycles
   task boot();
      sys_rst = 1;
      por_rst = 1;
      mode = erc_pkg::MODE_INIT;
      tick(12);
      sys_rst = 0;
      por_rst = 0;
      mode = erc_pkg::MODE_NORMAL;
   endtask : boot
   // load share enable per mode; normal follows the main regulator, restart is always on
   function automatic logic share_en(erc_pkg::erc_mode_e m, logic st, logic mo);
      return (mo && m == erc_pkg::MODE_NORMAL) || m == erc_pkg::MODE_RESTART
         || (m == erc_pkg::MODE_STOP && st);
   endfunction : share_en
   task finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   // whole run is about 215 cycles, so 100 us means a hang
   initial begin
      #100000;
      bad_count++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h9017));
      // share runs at the main regulator's 3.3 V, so the voltage bit matches it
      vs = erc_pkg::VSEL_3V3;
      boot();
      wr_ctl(0, 1);
      ck(sh, 1);
      ck(en, 1);
      ck(vq, erc_pkg::VSEL_3V3);
      wr_ctl(1, 1);
      ck(sf, 1);
      ck(sh, 1);
      clr_oc();
      ck(sf, 0);
      load = 2'h3;
      sag = 1;
      tick(6);
      ck(cl, 0);
      ck(uvf, 0);
      for (int i = 0; i < 5; i++) begin
         stay = 1'($urandom);
         main_on = 1'($urandom);
         mode = ml[i];
         tick(5);
         ck(en, share_en(mode, stay, main_on));
         mode = erc_pkg::MODE_NORMAL;
         main_on = 1'b1;
         tick(5);
         ck(en, 1);
      end
      // in normal mode sharing drops with the main regulator
      main_on = 1'b0;
      tick(5);
      ck(en, share_en(mode, stay, main_on));
      main_on = 1'b1;
      sys_rst = 1;
      tick(1);
      sys_rst = 0;
      tick(2);
      ck(sh, 1);
      wr_ctl(0, 0);
      ck(sf, 1);
      load = 2'h0;
      sag = 0;
      boot();
      v = 1'($urandom);
      vs = v;
      wr_ctl(1, 0);
      ck(sa, 1);
      ck(vq, v);
      ck(hp, 1);
      ck(lp, 0);
      wr_ctl(1, 1);
      ck(sh, 0);
      ck(sf, 0);
      wr_ctl(0, 0);
      ck(en, 0);
      wr_ctl(1, 0);
      load = 2'h3;
      tick(6);
      ck(cl, 1);
      clr_oc();
      ck(ocf, 1);
      load = 2'h1;
      tick(6);
      clr_oc();
      ck(ocf, 0);
      sag = 1;
      tick(6);
      ck(uvf, 1);
      sag = 0;
      // battery sag switches off, recovery restores, keep-on holds it
      for (int k = 0; k < 2; k++) begin
         keep = 1'(k);
         bat_uv = 1;
         tick(6);
         ck(en, 1'(k));
         bat_uv = 0;
         tick(6);
         ck(en, 1);
      end
      // output undervoltage is gone by now, so the clear takes
      clr_oc();
      ck(uvf, 0);
      mode = erc_pkg::MODE_STOP;
      load = 2'h0;
      tick(6);
      ck(en, 1);
      ck(lp, 1);
      ck(hp, 0);
      load = 2'h2;
      tick(6);
      ck(hp, 1);
      load = 2'h1;
      tick(6);
      ck(hp, 1);
      load = 2'h0;
      tick(6);
      ck(hp, 0);
      mode = erc_pkg::MODE_FAIL_SAFE;
      tick(5);
      ck(en, 0);
      finish_test();
   end
endmodule : test_ext_regulator_config_control
